// >>> dpm_pkg_gen.sv
// Constants for the dual PWM channel mapper, and the single PWM generator module.
`timescale 1ns/1ps

package dpm_pkg;
	// =====================================================================
	// Sizes
	localparam int NGEN     = 2;
	localparam int DUTY_W   = 8;
	localparam int SEL_W    = 2;
	localparam int CNT_W    = 10;
	localparam int TRIM_W   = 4;
	localparam int TICK_W   = 12;
	localparam int ADDR_W   = 8;
	localparam int CTRL_W   = DUTY_W + SEL_W;
	// =====================================================================
	// Register offsets (byte addresses)
	localparam logic [ADDR_W-1:0] OFS_GEN0_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_GEN1_CTRL = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_OUT_CTRL  = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MAP       = 8'h0C;
	localparam logic [ADDR_W-1:0] OFS_TRIM      = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;
	// =====================================================================
	// Field positions and reset values
	localparam int DUTY_LSB = 0;
	localparam int SEL_LSB  = 8;
	localparam int STAT_GEN_LSB = 8;
	localparam int STAT_DIR_LSB = 10;
	localparam logic [CTRL_W-1:0] CTRL_RST   = 10'h000;
	localparam logic [TRIM_W-1:0] TRIM_NOM   = 4'h8;
	localparam logic [TRIM_W-1:0] TRIM_RSVD  = 4'h0;
	// =====================================================================
	// Divider select codes and period lengths in base ticks
	localparam logic [SEL_W-1:0] SEL_1024 = 2'h0;
	localparam logic [SEL_W-1:0] SEL_512  = 2'h1;
	localparam logic [SEL_W-1:0] SEL_256  = 2'h2;
	localparam logic [SEL_W-1:0] SEL_FULL = 2'h3;
	localparam logic [CNT_W-1:0] LAST_1024 = 10'h3FF;
	localparam logic [CNT_W-1:0] LAST_512  = 10'h1FF;
	localparam logic [CNT_W-1:0] LAST_256  = 10'h0FF;
	// =====================================================================
	// Base rate offset per trim code, in parts per thousand
	localparam int TRIM_PERMILLE [16] = '{0, -372, -319, -269, -210, -155, -109, -58,
		0, 43, 89, 140, 195, 256, 324, 400};
	localparam int PERMILLE = 1000;

	function automatic logic [CNT_W-1:0] period_last(input logic [SEL_W-1:0] sel);
		case (sel)
			SEL_1024: period_last = LAST_1024;
			SEL_512:  period_last = LAST_512;
			default:  period_last = LAST_256;
		endcase
	endfunction

	// Position within the period scaled to 256 steps
	function automatic logic [DUTY_W-1:0] duty_step(input logic [CNT_W-1:0] cnt,
		input logic [SEL_W-1:0] sel);
		case (sel)
			SEL_1024: duty_step = cnt[9:2];
			SEL_512:  duty_step = cnt[8:1];
			default:  duty_step = cnt[7:0];
		endcase
	endfunction
endpackage

// =========================================================================
// One PWM generator, stepped by the shared base tick
module dpm_pwm_gen (
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	input  wire logic                      i_tick,
	input  wire logic [dpm_pkg::DUTY_W-1:0] i_duty,
	input  wire logic [dpm_pkg::SEL_W-1:0]  i_sel,
	output logic                           o_pwm,
	output logic                           o_wrap
);
	import dpm_pkg::*;

	logic [CNT_W-1:0]  cnt_q,  cnt_d;
	logic [DUTY_W-1:0] duty_q, duty_d;
	logic [SEL_W-1:0]  sel_q,  sel_d;
	logic              pwm_q,  pwm_d;
	logic              wrap_q, wrap_d;

	always_comb begin
		cnt_d  = cnt_q;
		duty_d = duty_q;
		sel_d  = sel_q;
		wrap_d = 1'b0;
		if (i_tick) begin
			if (cnt_q >= period_last(sel_q)) begin
				// Settings change only on a period boundary
				cnt_d  = '0;
				duty_d = i_duty;
				sel_d  = i_sel;
				wrap_d = 1'b1;
			end else begin
				cnt_d = cnt_q + 10'h001;
			end
		end
		if (sel_d == SEL_FULL)
			pwm_d = 1'b1;
		else
			pwm_d = duty_step(cnt_d, sel_d) < duty_d;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q  <= '0;
			duty_q <= '0;
			sel_q  <= SEL_1024;
			pwm_q  <= 1'b0;
			wrap_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			duty_q <= duty_d;
			sel_q  <= sel_d;
			pwm_q  <= pwm_d;
			wrap_q <= wrap_d;
		end
	end

	assign o_pwm  = pwm_q;
	assign o_wrap = wrap_q;

	// =====================================================================
	// Checks
	a_full_high: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		sel_q == SEL_FULL |-> pwm_q)
		else $error("constant high mode not high");
	a_duty_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		$changed(duty_q) || $changed(sel_q) |-> wrap_q)
		else $error("settings changed inside a period");
	a_zero_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(duty_q == 8'h00 && sel_q != SEL_FULL) |-> !pwm_q)
		else $error("zero duty drove high");
	a_last_step_low: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(sel_q == SEL_256 && cnt_q == LAST_256 && !wrap_q) |-> !pwm_q)
		else $error("last step of period not low");
	c_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n) wrap_q && pwm_q);
endmodule

// >>> dpm_top.sv
// Dual PWM channel mapper: APB registers, base tick, two generators, channel mux.
`timescale 1ns/1ps

module dpm_top #(
	parameter int CLK_HZ  = 100_000_000,
	parameter int BASE_HZ = 102_400,
	parameter int NCH     = 8
) (
	input  wire logic                       i_clk,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_psel,
	input  wire logic                       i_penable,
	input  wire logic                       i_pwrite,
	input  wire logic [dpm_pkg::ADDR_W-1:0] i_paddr,
	input  wire logic [31:0]                i_pwdata,
	input  wire logic [3:0]                 i_pstrb,
	output logic      [31:0]                o_prdata,
	output logic                            o_pready,
	output logic                            o_pslverr,
	input  wire logic [dpm_pkg::NGEN-1:0]   i_dir_in,
	output logic      [NCH-1:0]             o_chan
);
	import dpm_pkg::*;

	// =====================================================================
	// Base tick divider table, built at elaboration
	typedef logic [TICK_W-1:0] dpm_div_tab_t [16];

	function automatic dpm_div_tab_t build_div_tab();
		longint num;
		longint den;
		for (int i = 0; i < 16; i++) begin
			num = longint'(CLK_HZ) * PERMILLE;
			den = longint'(BASE_HZ) * (PERMILLE + TRIM_PERMILLE[i]);
			build_div_tab[i] = TICK_W'((num + den / 2) / den);
		end
	endfunction

	localparam dpm_div_tab_t DIV_TAB = build_div_tab();
	// Slowest trim gives the longest tick count, rounded as the table is
	localparam longint MAX_NUM = longint'(CLK_HZ) * PERMILLE;
	localparam longint MAX_DEN = longint'(BASE_HZ) * (PERMILLE + TRIM_PERMILLE[1]);
	localparam longint MAX_DIV = (MAX_NUM + MAX_DEN / 2) / MAX_DEN;

	// Refused at elaboration; ticks closer than three clocks are not served
	if (NCH < 1 || NCH > 8) begin : g_bad_nch
		$error("NCH must be 1 to 8");
	end
	if (MAX_DIV >= (longint'(1) << TICK_W) || DIV_TAB[15] < 3) begin : g_bad_ratio
		$error("clock to base rate ratio out of range");
	end

	// =====================================================================
	// Register state
	logic [CTRL_W-1:0] gen_ctrl_q [NGEN];
	logic [CTRL_W-1:0] gen_ctrl_d [NGEN];
	logic [NCH-1:0]    out_en_q, out_en_d;
	logic [NCH-1:0]    map_q,    map_d;
	logic [TRIM_W-1:0] trim_q,   trim_d;
	logic [31:0]       prdata_q, prdata_d;
	logic              pready_q, pready_d;
	logic              pslverr_q, pslverr_d;

	logic [NGEN-1:0]   dir_meta_q, dir_sync_q;
	logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
	logic              tick_q,     tick_d;
	logic [NGEN-1:0]   gen_pwm;
	logic [NGEN-1:0]   gen_wrap;
	logic [NCH-1:0]    chan_q, chan_d;

	logic setup_ph;
	logic wr_acc;
	assign setup_ph = i_psel && !i_penable;
	assign wr_acc   = i_psel && i_penable && pready_q && i_pwrite;

	// =====================================================================
	// Bus helpers
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		case (a)
			OFS_GEN0_CTRL, OFS_GEN1_CTRL, OFS_OUT_CTRL,
			OFS_MAP, OFS_TRIM, OFS_STATUS: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = strb[b] ? wd[8*b +: 8] : old[8*b +: 8];
	endfunction

	// =====================================================================
	// APB slave: one wait-free access phase, errors on holes
	always_comb begin
		prdata_d  = prdata_q;
		pready_d  = setup_ph;
		pslverr_d = 1'b0;
		if (setup_ph) begin
			pslverr_d = !is_mapped(i_paddr);
			prdata_d  = '0;
			if (!i_pwrite) begin
				case (i_paddr)
					OFS_GEN0_CTRL: prdata_d[CTRL_W-1:0] = gen_ctrl_q[0];
					OFS_GEN1_CTRL: prdata_d[CTRL_W-1:0] = gen_ctrl_q[1];
					OFS_OUT_CTRL:  prdata_d[NCH-1:0]    = out_en_q;
					OFS_MAP:       prdata_d[NCH-1:0]    = map_q;
					OFS_TRIM:      prdata_d[TRIM_W-1:0] = trim_q;
					OFS_STATUS: begin
						prdata_d[NCH-1:0] = chan_q;
						prdata_d[STAT_GEN_LSB +: NGEN] = gen_pwm;
						prdata_d[STAT_DIR_LSB +: NGEN] = dir_sync_q;
					end
					default: prdata_d = '0;
				endcase
			end
		end
	end

	// Register writes take effect at the access edge
	always_comb begin
		logic [31:0] wv;
		wv = '0;
		for (int g = 0; g < NGEN; g++)
			gen_ctrl_d[g] = gen_ctrl_q[g];
		out_en_d = out_en_q;
		map_d    = map_q;
		trim_d   = trim_q;
		if (wr_acc) begin
			case (i_paddr)
				OFS_GEN0_CTRL: begin
					wv = merge(32'(gen_ctrl_q[0]), i_pwdata, i_pstrb);
					gen_ctrl_d[0] = wv[CTRL_W-1:0];
				end
				OFS_GEN1_CTRL: begin
					wv = merge(32'(gen_ctrl_q[1]), i_pwdata, i_pstrb);
					gen_ctrl_d[1] = wv[CTRL_W-1:0];
				end
				OFS_OUT_CTRL: begin
					wv = merge(32'(out_en_q), i_pwdata, i_pstrb);
					out_en_d = wv[NCH-1:0];
				end
				OFS_MAP: begin
					wv = merge(32'(map_q), i_pwdata, i_pstrb);
					map_d = wv[NCH-1:0];
				end
				OFS_TRIM: begin
					wv = merge(32'(trim_q), i_pwdata, i_pstrb);
					trim_d = wv[TRIM_W-1:0];
				end
				default: wv = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int g = 0; g < NGEN; g++)
				gen_ctrl_q[g] <= CTRL_RST;
			out_en_q  <= '0;
			map_q     <= '0;
			trim_q    <= TRIM_NOM;
			prdata_q  <= '0;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			for (int g = 0; g < NGEN; g++)
				gen_ctrl_q[g] <= gen_ctrl_d[g];
			out_en_q  <= out_en_d;
			map_q     <= map_d;
			trim_q    <= trim_d;
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// =====================================================================
	// Base tick from the trimmed internal rate
	always_comb begin
		logic [TICK_W-1:0] div;
		// Reserved trim code falls back to nominal rather than stopping
		div = (trim_q == TRIM_RSVD) ? DIV_TAB[TRIM_NOM] : DIV_TAB[trim_q];
		tick_d = 1'b0;
		if (tick_cnt_q >= div - 12'h001) begin
			tick_cnt_d = '0;
			tick_d     = 1'b1;
		end else begin
			tick_cnt_d = tick_cnt_q + 12'h001;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_cnt_q <= '0;
			tick_q     <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q     <= tick_d;
		end
	end

	// =====================================================================
	// Generators, all sharing the one tick
	for (genvar g = 0; g < NGEN; g++) begin : g_gen
		dpm_pwm_gen u_gen (
			.i_clk   (i_clk),
			.i_rst_n (i_rst_n),
			.i_tick  (tick_q),
			.i_duty  (gen_ctrl_q[g][DUTY_LSB +: DUTY_W]),
			.i_sel   (gen_ctrl_q[g][SEL_LSB +: SEL_W]),
			.o_pwm   (gen_pwm[g]),
			.o_wrap  (gen_wrap[g])
		);
	end

	// =====================================================================
	// Direct inputs are asynchronous pins
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dir_meta_q <= '0;
			dir_sync_q <= '0;
		end else begin
			dir_meta_q <= i_dir_in;
			dir_sync_q <= dir_meta_q;
		end
	end

	// =====================================================================
	// Channel mux: generator or direct input, same selector bit
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			if (out_en_q[c])
				chan_d[c] = gen_pwm[map_q[c]];
			else
				chan_d[c] = dir_sync_q[map_q[c]];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			chan_q <= '0;
		else
			chan_q <= chan_d;
	end

	assign o_chan    = chan_q;
	assign o_prdata  = prdata_q;
	assign o_pready  = pready_q;
	assign o_pslverr = pslverr_q;

	// =====================================================================
	// Checks
	a_apb_ready: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		setup_ph |=> pready_q ##1 !pready_q)
		else $error("access phase not answered in one cycle");
	a_unmapped_err: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(setup_ph && !is_mapped(i_paddr)) |=> pslverr_q && prdata_q == 32'h0)
		else $error("hole address not flagged");
	a_ctrl_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wr_acc && i_paddr == OFS_GEN0_CTRL && i_pstrb == 4'hF)
		|=> gen_ctrl_q[0] == $past(i_pwdata[CTRL_W-1:0]))
		else $error("generator control write lost");
	a_tick_space: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		tick_q |=> !tick_q [*2])
		else $error("base ticks too close");
	a_chan_gen: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		($stable(map_q) && $stable(out_en_q) && out_en_q[0] && map_q[0])
		|=> o_chan[0] == $past(gen_pwm[1]))
		else $error("channel 0 not following generator 1");
	a_dir_path: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		($stable(map_q) && $stable(out_en_q) && !out_en_q[0] && !map_q[0])
		|=> o_chan[0] == $past(dir_sync_q[0]))
		else $error("channel 0 not following direct input 0");

	// =====================================================================
	// Register side checks
	a_rd_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!setup_ph |=> $stable(prdata_q))
		else $error("read data moved outside a setup");
	a_mapped_ok: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(setup_ph && is_mapped(i_paddr)) |=> !pslverr_q)
		else $error("mapped address flagged");
	a_hole_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wr_acc && !is_mapped(i_paddr))
		|=> $stable(out_en_q) && $stable(map_q) && $stable(trim_q))
		else $error("write to a hole changed a register");
	a_trim_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wr_acc && i_paddr == OFS_TRIM && i_pstrb[0])
		|=> trim_q == $past(i_pwdata[TRIM_W-1:0]))
		else $error("trim write lost");
	a_map_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wr_acc && i_paddr == OFS_MAP && i_pstrb[0])
		|=> map_q == $past(i_pwdata[NCH-1:0]))
		else $error("map write lost");
	a_out_write: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(wr_acc && i_paddr == OFS_OUT_CTRL && i_pstrb[0])
		|=> out_en_q == $past(i_pwdata[NCH-1:0]))
		else $error("output control write lost");

	// =====================================================================
	// Scenario covers
	c_dir_chan: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		o_chan[0] && !out_en_q[0]);
	c_err: cover property (@(posedge i_clk) disable iff (!i_rst_n) pslverr_q);
	c_gen1_wrap: cover property (@(posedge i_clk) disable iff (!i_rst_n) gen_wrap[1]);
	c_chan_hi: cover property (@(posedge i_clk) disable iff (!i_rst_n) o_chan[0] && out_en_q[0]);
endmodule

// >>> dpm_sw_bank.sv
// Model of the eight load switches driven by the channel outputs.
`timescale 1ns/1ps

module dpm_sw_bank #(
	parameter int NCH = 8
) (
	input  wire logic           i_clk,
	input  wire logic           i_rst_n,
	input  wire logic [NCH-1:0] i_chan,
	output logic      [NCH-1:0] o_load
);
	logic [NCH-1:0] load_d;
	logic [NCH-1:0] load_q;

	// Each switch follows its drive one clock later; durations are unchanged
	always_comb begin
		load_d = i_chan;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			load_q <= '0;
		end else begin
			load_q <= load_d;
		end
	end

	assign o_load = load_q;
endmodule

// >>> dpm_top_tb_top.sv
// Self-checking bench for the dual PWM channel mapper.
`timescale 1ns/1ps

module dpm_top_tb_top;
	import dpm_pkg::*;
	localparam int CLK_HZ  = 100_000_000;
	// Four clocks per base tick keeps every period short
	localparam int BASE_HZ = 25_000_000;
	localparam int LIM     = 9000;

	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'hF;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [1:0]  dir_in = 2'h0;
	logic [7:0]  chan;
	logic [7:0]  load;
	logic [31:0] rd;
	logic        er;
	int          err_total = 0;
	int          n_tests = 0;

	dpm_top #(.CLK_HZ(CLK_HZ), .BASE_HZ(BASE_HZ), .NCH(8)) u_dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.i_dir_in(dir_in), .o_chan(chan));

	dpm_sw_bank #(.NCH(8)) u_sw (.i_clk(clk), .i_rst_n(rst_n), .i_chan(chan), .o_load(load));

	always #5 clk = ~clk;

	// =====================================================================
	// Checking and bus tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		input logic [3:0] st);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= st;
		@(posedge clk);
		penable <= 1'b1;
		// Read at the edge itself, before the slave's flops update
		@(posedge clk);
		while (pready !== 1'b1 && k < 50) begin
			k++;
			@(posedge clk);
		end
		chk("pready", 1'b1, pready);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] wd);
		apb(1'b1, a, wd, 4'hF);
	endtask

	task automatic gen(input int g, input logic [7:0] d, input logic [1:0] s);
		wreg(g ? OFS_GEN1_CTRL : OFS_GEN0_CTRL, {22'h0, s, d});
	endtask

	// Counts negedges on which the load keeps level v, from the current one
	task automatic run_len(input int ch, input logic v, input int lim, output int n);
		n = 0;
		while (load[ch] === v && n < lim) begin
			n++;
			@(negedge clk);
		end
	endtask

	// Skips to a period start, then measures high time and full period
	task automatic meas(input int ch, output int hi, output int per);
		int n;
		@(negedge clk);
		run_len(ch, 1'b1, LIM, n);
		run_len(ch, 1'b0, LIM, n);
		run_len(ch, 1'b1, LIM, hi);
		run_len(ch, 1'b0, LIM, per);
		per += hi;
	endtask

	function automatic int per_cyc(input logic [1:0] s, input int tk);
		return (s == SEL_1024 ? 1024 : s == SEL_512 ? 512 : 256) * tk;
	endfunction

	function automatic int tick_of(input logic [3:0] t);
		real r;
		r = CLK_HZ * 1000.0 / (BASE_HZ * (1000.0 + TRIM_PERMILLE[t]));
		return $rtoi(r + 0.5);
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// =====================================================================
	// Main sequence
	initial begin
		int hi;
		int per;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] m;
		logic [7:0] x;
		logic [1:0] dv;
		logic [3:0] trims [4];
		void'($urandom(32'h12FC));
		trims = '{4'h1, 4'hF, 4'h0, 4'h8};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 4; a++) begin
			apb(1'b0, 8'(a * 4), 32'h0, 4'hF);
			chk("reset reg", 32'h0, rd);
		end
		apb(1'b0, OFS_TRIM, 32'h0, 4'hF);
		chk("trim reset", {28'h0, TRIM_NOM}, rd);
		apb(1'b0, 8'h18, 32'h0, 4'hF);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, 8'h18, 32'hFFFFFFFF, 4'hF);
		chk("hole write err", 32'h1, {31'h0, er});
		apb(1'b0, OFS_OUT_CTRL, 32'h0, 4'hF);
		chk("hole write kept", 32'h0, rd);
		apb(1'b1, OFS_GEN0_CTRL, 32'h3FF, 4'h1);
		apb(1'b0, OFS_GEN0_CTRL, 32'h0, 4'hF);
		chk("strobe", 32'h0FF, rd);
		m = {6'($urandom()), 2'b10};
		wreg(OFS_OUT_CTRL, 32'hFF);
		wreg(OFS_MAP, {24'h0, m});
		for (int s = 0; s < 3; s++) begin
			d = 8'($urandom_range(1, 254));
			e = ~d;
			gen(0, d, 2'(s));
			gen(1, e, SEL_256);
			meas(0, hi, per);
			chk("period", per_cyc(2'(s), 4), per);
			chk("high", d * per_cyc(2'(s), 4) / 256, hi);
			if (s == 2) begin
				meas(1, hi, per);
				chk("gen1 high", e * 4, hi);
			end
		end
		for (int c = 0; c < 2; c++) begin
			d = c ? 8'hFF : 8'h01;
			gen(0, d, SEL_256);
			meas(0, hi, per);
			chk("corner high", d * 4, hi);
			chk("corner low", 1024 - d * 4, per - hi);
		end
		gen(0, 8'h00, SEL_256);
		repeat (1100) @(posedge clk);
		@(negedge clk);
		run_len(0, 1'b0, 2100, hi);
		chk("zero duty", 2100, hi);
		gen(0, 8'h00, SEL_FULL);
		repeat (1100) @(posedge clk);
		@(negedge clk);
		run_len(0, 1'b1, 2100, hi);
		chk("full on", 2100, hi);
		gen(0, 8'h40, SEL_256);
		meas(0, hi, per);
		fork
			gen(0, 8'hC0, SEL_256);
			run_len(0, 1'b1, LIM, hi);
		join
		chk("old duty", 32'h100, hi);
		run_len(0, 1'b0, LIM, per);
		run_len(0, 1'b1, LIM, hi);
		chk("new duty", 32'h300, hi);
		foreach (trims[i]) begin
			wreg(OFS_TRIM, {28'h0, trims[i]});
			apb(1'b0, OFS_TRIM, 32'h0, 4'hF);
			chk("trim rb", {28'h0, trims[i]}, rd);
			meas(0, hi, per);
			chk("trim period", 256 * tick_of(trims[i]), per);
		end
		gen(0, 8'h00, SEL_FULL);
		gen(1, 8'h00, SEL_256);
		repeat (1100) @(posedge clk);
		repeat (6) begin
			e = 8'($urandom());
			m = 8'($urandom());
			dv = 2'($urandom());
			wreg(OFS_OUT_CTRL, {24'h0, e});
			wreg(OFS_MAP, {24'h0, m});
			dir_in <= dv;
			repeat (6) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				x[i] = e[i] ? ~m[i] : dv[m[i]];
			end
			@(negedge clk);
			chk("channels", {24'h0, x}, {24'h0, chan});
			apb(1'b0, OFS_STATUS, 32'h0, 4'hF);
			chk("status", {20'h0, dv, 2'b01, x}, rd);
		end
		conclude();
	end

	initial begin
		// Well above the longest expected run, still under the cycle budget
		#800_000;
		err_total++;
		conclude();
	end
endmodule
